// ===== verilog/emb_pkg.sv
// shared constants for the embedded multiplier tile
package emb_pkg;

  // operand and product widths
  localparam int unsigned EMB_WIDE_W   = 18;
  localparam int unsigned EMB_NARROW_W = 9;
  localparam int unsigned EMB_PROD_W   = 36;
  localparam int unsigned EMB_HALF_W   = 18;

  // register bus geometry
  localparam int unsigned EMB_ADDR_W = 4;
  localparam int unsigned EMB_DATA_W = 32;
  localparam int unsigned EMB_BE_W   = 4;

  // byte offsets of the register words
  localparam logic [3:0] EMB_OFS_CTRL   = 4'h0;
  localparam logic [3:0] EMB_OFS_PROD_L = 4'h4;
  localparam logic [3:0] EMB_OFS_PROD_H = 4'h8;

  // control register field positions
  localparam int unsigned EMB_CTRL_MODE_BIT  = 0;
  localparam int unsigned EMB_CTRL_AREG_BIT  = 1;
  localparam int unsigned EMB_CTRL_BREG_BIT  = 2;
  localparam int unsigned EMB_CTRL_SREG_BIT  = 3;
  localparam int unsigned EMB_CTRL_OREG_BIT  = 4;
  localparam int unsigned EMB_CTRL_W         = 5;

  // control reset value: wide mode, every stage bypassed
  localparam logic [4:0] EMB_CTRL_RST = 5'h00;

  // high product word field positions
  localparam int unsigned EMB_PH_TOP_W      = 4;
  localparam int unsigned EMB_PH_SIGNED_BIT = 8;
  localparam int unsigned EMB_PH_MODE_BIT   = 9;

  // multiplier arrangement
  typedef enum logic {
    EMB_MODE_WIDE,
    EMB_MODE_NARROW
  } emb_mode_t;

endpackage

// ===== verilog/emb_mul.sv
// embedded multiplier tile with avalon-mm configuration port
//
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/1ns

module emb_mul
  import emb_pkg::*;
#(
  parameter int unsigned WIDE_W   = EMB_WIDE_W,
  parameter int unsigned NARROW_W = EMB_NARROW_W
) (
  input  wire logic                  core_clk_in,
  input  wire logic                  rst_b_in,
  // tile datapath
  input  wire logic                  tile_ena_in,
  input  wire logic                  tile_aclr_in,
  input  wire logic [EMB_WIDE_W-1:0] oper_a_in,
  input  wire logic [EMB_WIDE_W-1:0] oper_b_in,
  input  wire logic                  sign_a_in,
  input  wire logic                  sign_b_in,
  output logic      [EMB_PROD_W-1:0] product_out,
  output logic                       product_signed_out,
  // avalon-mm slave
  input  wire logic [EMB_ADDR_W-1:0] avs_address_in,
  input  wire logic                  avs_read_in,
  input  wire logic                  avs_write_in,
  input  wire logic [EMB_DATA_W-1:0] avs_writedata_in,
  input  wire logic [EMB_BE_W-1:0]   avs_byteenable_in,
  output logic      [EMB_DATA_W-1:0] avs_readdata_out,
  output logic                       avs_waitrequest_out
);

  // widen an operand to 18 bits: sign-extend when signed, zero-extend otherwise
  function automatic logic [EMB_WIDE_W-1:0] ext_narrow(
    input logic [EMB_NARROW_W-1:0] v,
    input logic                    sgn
  );
    logic fill;
    fill = sgn & v[EMB_NARROW_W-1];
    ext_narrow = {{(EMB_WIDE_W-EMB_NARROW_W){fill}}, v};
  endfunction

  // 18x18 with per-operand sign; a 19-bit signed view covers both cases exactly
  function automatic logic [EMB_PROD_W-1:0] mul_wide(
    input logic [EMB_WIDE_W-1:0] a,
    input logic [EMB_WIDE_W-1:0] b,
    input logic                  sa,
    input logic                  sb
  );
    logic signed [EMB_WIDE_W:0]     ea;
    logic signed [EMB_WIDE_W:0]     eb;
    logic signed [2*EMB_WIDE_W+1:0] p;
    ea = $signed({sa & a[EMB_WIDE_W-1], a});
    eb = $signed({sb & b[EMB_WIDE_W-1], b});
    p  = ea * eb;
    mul_wide = p[EMB_PROD_W-1:0];
  endfunction

  // narrow lanes keep 18 product bits each: enough for any 9x9 sign mix
  function automatic logic [EMB_PROD_W-1:0] pack_lanes(
    input logic [EMB_PROD_W-1:0] hi,
    input logic [EMB_PROD_W-1:0] lo
  );
    pack_lanes = {hi[EMB_HALF_W-1:0], lo[EMB_HALF_W-1:0]};
  endfunction

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  // map: ctrl at 0x0, product low word at 0x4, product high word at 0x8
  // ctrl bits: mode, a stage, b stage, sign stage, output stage (bit 0 up)
  // high word: product top nibble, signed flag at bit 8, mode at bit 9
  // product words are read-only; a torn pair is possible while enabled
  logic [EMB_CTRL_W-1:0] ctrl_q;
  logic [EMB_CTRL_W-1:0] ctrl_d;
  logic                  wait_q;
  logic                  wait_d;
  logic [EMB_DATA_W-1:0] rdata_q;
  logic [EMB_DATA_W-1:0] rdata_d;
  logic                  bus_req;
  logic                  wr_commit;
  logic                  rd_take;
  logic                  ctrl_wr;

  assign bus_req   = avs_read_in | avs_write_in;
  assign wr_commit = avs_write_in & ~wait_q;
  assign rd_take   = avs_read_in & wait_q;
  assign ctrl_wr   = wr_commit & (avs_address_in == EMB_OFS_CTRL) & avs_byteenable_in[0];

  // one wait cycle per access: request seen, then released at the next edge
  always_comb begin
    wait_d = 1'b1;
    if (bus_req && wait_q) begin
      wait_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= wait_d;
    end
  end

  // only the low byte lane carries control bits; other lanes are ignored
  // writes to the product words fall through here and are dropped
  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrl_wr) begin
      ctrl_d = avs_writedata_in[EMB_CTRL_W-1:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_q <= EMB_CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // read word is chosen from the address alone; the flop decides when it lands
  always_comb begin
    rdata_d = '0;
    case (avs_address_in)
      EMB_OFS_CTRL: begin
        rdata_d[EMB_CTRL_W-1:0] = ctrl_q;
      end
      EMB_OFS_PROD_L: begin
        rdata_d = product_out[EMB_DATA_W-1:0];
      end
      EMB_OFS_PROD_H: begin
        rdata_d[EMB_PH_TOP_W-1:0]  = product_out[EMB_PROD_W-1:EMB_DATA_W];
        rdata_d[EMB_PH_SIGNED_BIT] = product_signed_out;
        rdata_d[EMB_PH_MODE_BIT]   = ctrl_q[EMB_CTRL_MODE_BIT];
      end
      default: begin
        rdata_d = '0;
      end
    endcase
  end

  // load only when a read is taken, so the word stands until the next read
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_q <= rdata_d;
    end
  end

  assign avs_waitrequest_out = wait_q;
  assign avs_readdata_out    = rdata_q;

  // ---------------------------------------------------------------
  // tile configuration
  // ---------------------------------------------------------------
  emb_mode_t mode;
  logic      a_reg_en;
  logic      b_reg_en;
  logic      s_reg_en;
  logic      o_reg_en;

  assign mode     = ctrl_q[EMB_CTRL_MODE_BIT] ? EMB_MODE_NARROW : EMB_MODE_WIDE;
  assign a_reg_en = ctrl_q[EMB_CTRL_AREG_BIT];
  assign b_reg_en = ctrl_q[EMB_CTRL_BREG_BIT];
  assign s_reg_en = ctrl_q[EMB_CTRL_SREG_BIT];
  assign o_reg_en = ctrl_q[EMB_CTRL_OREG_BIT];

  // ---------------------------------------------------------------
  // input stage
  // ---------------------------------------------------------------
  logic [EMB_WIDE_W-1:0] a_q;
  logic [EMB_WIDE_W-1:0] b_q;
  logic                  sa_q;
  logic                  sb_q;
  logic                  tile_clr;

  // either the fabric clear or the system reset empties the tile
  assign tile_clr = ~rst_b_in | tile_aclr_in;

  always_ff @(posedge core_clk_in or posedge tile_clr) begin
    if (tile_clr) begin
      a_q <= 18'h0_0000;
    end else if (tile_ena_in) begin
      a_q <= oper_a_in;
    end
  end

  always_ff @(posedge core_clk_in or posedge tile_clr) begin
    if (tile_clr) begin
      b_q <= 18'h0_0000;
    end else if (tile_ena_in) begin
      b_q <= oper_b_in;
    end
  end

  // sign flops sit at the input stage so they line up with registered operands
  // both share one enable, but the sign stage has its own bypass bit, so a sign change lands a cycle apart from its data if it differs from the a/b stages
  always_ff @(posedge core_clk_in or posedge tile_clr) begin
    if (tile_clr) begin
      sa_q <= 1'b0;
    end else if (tile_ena_in) begin
      sa_q <= sign_a_in;
    end
  end

  always_ff @(posedge core_clk_in or posedge tile_clr) begin
    if (tile_clr) begin
      sb_q <= 1'b0;
    end else if (tile_ena_in) begin
      sb_q <= sign_b_in;
    end
  end

  logic [EMB_WIDE_W-1:0] a_sel;
  logic [EMB_WIDE_W-1:0] b_sel;
  logic                  sa_sel;
  logic                  sb_sel;

  // each stage is a mux around its flop, picked live from the control word
  always_comb begin
    a_sel  = oper_a_in;
    b_sel  = oper_b_in;
    sa_sel = sign_a_in;
    sb_sel = sign_b_in;
    if (a_reg_en) begin
      a_sel = a_q;
    end
    if (b_reg_en) begin
      b_sel = b_q;
    end
    // unregistered sign follows the live pin, so a run-time change hits this cycle
    if (s_reg_en) begin
      sa_sel = sa_q;
      sb_sel = sb_q;
    end
  end

  // ---------------------------------------------------------------
  // multiplier array
  // ---------------------------------------------------------------
  logic [EMB_PROD_W-1:0] prod_wide;
  logic [EMB_PROD_W-1:0] prod_lo_full;
  logic [EMB_PROD_W-1:0] prod_hi_full;
  logic [EMB_WIDE_W-1:0] a_lo_x;
  logic [EMB_WIDE_W-1:0] b_lo_x;
  logic [EMB_WIDE_W-1:0] a_hi_x;
  logic [EMB_WIDE_W-1:0] b_hi_x;
  logic [EMB_PROD_W-1:0] prod_comb;
  logic                  signed_comb;

  assign prod_wide = mul_wide(a_sel, b_sel, sa_sel, sb_sel);

  // narrow lanes are pre-extended, so they multiply as signed on the wide path
  // and neither lane can carry into the other
  assign a_lo_x = ext_narrow(a_sel[EMB_NARROW_W-1:0], sa_sel);
  assign b_lo_x = ext_narrow(b_sel[EMB_NARROW_W-1:0], sb_sel);
  assign a_hi_x = ext_narrow(a_sel[2*EMB_NARROW_W-1:EMB_NARROW_W], sa_sel);
  assign b_hi_x = ext_narrow(b_sel[2*EMB_NARROW_W-1:EMB_NARROW_W], sb_sel);

  assign prod_lo_full = mul_wide(a_lo_x, b_lo_x, 1'b1, 1'b1);
  assign prod_hi_full = mul_wide(a_hi_x, b_hi_x, 1'b1, 1'b1);

  always_comb begin
    case (mode)
      EMB_MODE_WIDE: begin
        prod_comb = prod_wide;
      end
      EMB_MODE_NARROW: begin
        prod_comb = pack_lanes(prod_hi_full, prod_lo_full);
      end
      default: begin
        prod_comb = '0;
      end
    endcase
  end

  assign signed_comb = sa_sel | sb_sel;

  // ---------------------------------------------------------------
  // output stage
  // ---------------------------------------------------------------
  logic [EMB_PROD_W-1:0] p_q;
  logic                  ps_q;
  logic [EMB_PROD_W-1:0] out_q;
  logic                  out_s_q;

  // optional product stage
  always_ff @(posedge core_clk_in or posedge tile_clr) begin
    if (tile_clr) begin
      p_q <= 36'h0_0000_0000;
    end else if (tile_ena_in) begin
      p_q <= prod_comb;
    end
  end

  always_ff @(posedge core_clk_in or posedge tile_clr) begin
    if (tile_clr) begin
      ps_q <= 1'b0;
    end else if (tile_ena_in) begin
      ps_q <= signed_comb;
    end
  end

  // final flop keeps outputs glitch free; bypass of the optional stage only
  // removes its cycle, so total latency is 1, 2 or 3 edges
  // the bypass mux reads the live control bit, so a change mid-stream
  // may drop or repeat one product; quiesce the tile before switching
  always_ff @(posedge core_clk_in or posedge tile_clr) begin
    if (tile_clr) begin
      out_q <= 36'h0_0000_0000;
    end else if (tile_ena_in) begin
      out_q <= o_reg_en ? p_q : prod_comb;
    end
  end

  always_ff @(posedge core_clk_in or posedge tile_clr) begin
    if (tile_clr) begin
      out_s_q <= 1'b0;
    end else if (tile_ena_in) begin
      out_s_q <= o_reg_en ? ps_q : signed_comb;
    end
  end

  assign product_out        = out_q;
  assign product_signed_out = out_s_q;

endmodule

// ===== sim/emb_mul_sva.sv
// port checker for the multiplier tile
`timescale 1ns/1ns
module emb_mul_sva
  import emb_pkg::*;
(
  input wire logic        core_clk_in,
  input wire logic        rst_b_in,
  input wire logic        tile_ena_in,
  input wire logic        tile_aclr_in,
  input wire logic [17:0] oper_a_in,
  input wire logic [17:0] oper_b_in,
  input wire logic        sign_a_in,
  input wire logic        sign_b_in,
  input wire logic [35:0] product_out,
  input wire logic        product_signed_out,
  input wire logic [3:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out
);
  logic [4:0] ctrl_q;
  wire        rq = avs_read_in | avs_write_in;
  wire        ok = tile_ena_in & !tile_aclr_in;
  wire        c2 = ctrl_q == 5'h10 || ctrl_q == 5'h0E;
  // shadow of the control word, followed from accepted writes
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      ctrl_q <= 5'h00;
    else if (avs_write_in && !avs_waitrequest_out && avs_address_in == EMB_OFS_CTRL &&
             avs_byteenable_in[0])
      ctrl_q <= avs_writedata_in[4:0];
  end
  function automatic logic [36:0] ref_f(logic [17:0] a, b, logic sa, sb, m);
    logic signed [37:0] w;
    logic signed [19:0] l;
    logic signed [19:0] h;
    w = $signed({sa & a[17], a}) * $signed({sb & b[17], b});
    l = $signed({sa & a[8], a[8:0]}) * $signed({sb & b[8], b[8:0]});
    h = $signed({sa & a[17], a[17:9]}) * $signed({sb & b[17], b[17:9]});
    return {sa | sb, m ? {h[17:0], l[17:0]} : w[35:0]};
  endfunction
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  a_wait_one: assert property (rq && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("request not answered after one wait cycle");
  a_wait_short: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  a_wait_idle: assert property (!rq && avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest dropped without a request");
  a_clear_zero: assert property (tile_aclr_in |->
    product_out == '0 && !product_signed_out)
    else $error("product not zero under clear");
  a_ena_hold: assert property (!tile_ena_in && !tile_aclr_in ##1 !tile_aclr_in
    |-> $stable(product_out) && $stable(product_signed_out))
    else $error("product moved with enable low");
  a_bypass_prod: assert property (ctrl_q[4:1] == 4'h0 && ok |=>
    tile_aclr_in || {product_signed_out, product_out} ==
    ref_f($past(oper_a_in), $past(oper_b_in), $past(sign_a_in), $past(sign_b_in),
    $past(ctrl_q[0])))
    else $error("bypassed product wrong");
  a_sign_flag: assert property (ctrl_q[4:3] == 2'h0 && ok |=>
    tile_aclr_in || product_signed_out == $past(sign_a_in | sign_b_in))
    else $error("product sign flag wrong");
  a_stage_lat: assert property (c2 && ok ##1 c2 && ok ##1 !tile_aclr_in |->
    {product_signed_out, product_out} == ref_f($past(oper_a_in, 2), $past(oper_b_in, 2),
    $past(sign_a_in, 2), $past(sign_b_in, 2), 1'b0))
    else $error("registered stage latency wrong");
endmodule

// ===== sim/emb_fabric.sv
// fabric-side operand source for the multiplier tile
`timescale 1ns/1ns
module emb_fabric (
  input  wire logic [35:0] word_in,
  input  wire logic        sa_in,
  input  wire logic        sb_in,
  output logic      [17:0] a_out,
  output logic      [17:0] b_out,
  output logic             sa_out,
  output logic             sb_out
);
  assign a_out = word_in[17:0];
  assign b_out = word_in[35:18];
  // one sign per operand feeds both narrow halves
  assign sa_out = sa_in;
  assign sb_out = sb_in;
endmodule

// ===== sim/emb_mul_tb_top.sv
// self-checking bench for the multiplier tile
`timescale 1ns/1ns
module emb_mul_tb_top
  import emb_pkg::*;
;
  logic        clk, rst_b, ena, aclr, sa, sb, rd, wr, wq, sa_f, sb_f, psg;
  logic [35:0] word, prod;
  logic [17:0] a, b;
  logic [3:0]  adr, be;
  logic [31:0] wdat, rdat, rdq;
  logic [31:0] seed = 32'h33;
  logic [36:0] last;
  logic [4:0]  cfg[8] = '{5'h00, 5'h01, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h1E, 5'h1F};
  int          err_total, check_count;
  emb_fabric fab (.word_in(word), .sa_in(sa), .sb_in(sb), .a_out(a), .b_out(b),
    .sa_out(sa_f), .sb_out(sb_f));
  emb_mul uut (.core_clk_in(clk), .rst_b_in(rst_b), .tile_ena_in(ena), .tile_aclr_in(aclr),
    .oper_a_in(a), .oper_b_in(b), .sign_a_in(sa_f), .sign_b_in(sb_f), .product_out(prod),
    .product_signed_out(psg), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdat), .avs_byteenable_in(be), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wq));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic longint sx(logic [17:0] v, int w, logic s);
    longint r;
    r = longint'(v) & ((longint'(1) << w) - 1);
    if (s && v[w-1]) r -= longint'(1) << w;
    return r;
  endfunction
  function automatic logic [36:0] model(logic [17:0] x, y, logic s, t, m);
    longint p, l, h;
    p = sx(x, 18, s) * sx(y, 18, t);
    l = sx(x, 9, s) * sx(y, 9, t);
    h = sx(x >> 9, 9, s) * sx(y >> 9, 9, t);
    return {s | t, m ? {h[17:0], l[17:0]} : p[35:0]};
  endfunction
  task automatic chk(string n, logic [36:0] got, exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic bus(logic [3:0] ad, logic w, logic [31:0] d, logic [3:0] e);
    int n;
    @(posedge clk);
    adr <= ad;
    wr <= w;
    rd <= !w;
    wdat <= d;
    be <= e;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 50);
    rdq = rdat;
    if (n >= 50) err_total++;
    rd <= 0;
    wr <= 0;
  endtask
  task automatic run(logic [4:0] c);
    logic [36:0] q[$];
    logic [31:0] r, s;
    logic [35:0] w;
    int          lat;
    bus(EMB_OFS_CTRL, 1, {27'h0, c}, 4'h1);
    lat = 1 + c[1] + c[4];
    for (int i = 0; i < 30; i++) begin
      r = nxt();
      s = nxt();
      w = {s[17:0], r[17:0]};
      // corner operands: most negative times all ones
      if (r[20:18] == 3'h0) w = {18'h3FFFF, 18'h20000};
      @(posedge clk);
      word <= w;
      sa <= r[31];
      sb <= s[31];
      q.push_back(model(w[17:0], w[35:18], r[31], s[31], c[0]));
      @(negedge clk);
      if (i >= lat)
        chk("product", {psg, prod}, q[i - lat]);
    end
    last = q[29];
  endtask
  task end_sim();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    {ena, aclr, sa, sb, rd, wr, word, adr, wdat, be} = '0;
    rst_b = 0;
    repeat (20) @(posedge clk);
    chk("rst_prod", {psg, prod}, 37'h0);
    rst_b <= 1;
    ena <= 1;
    foreach (cfg[i]) run(cfg[i]);
    repeat (3) @(posedge clk);
    ena <= 0;
    word <= ~word;
    bus(EMB_OFS_PROD_L, 0, 32'h0, 4'hF);
    chk("prod_l", rdq, last[31:0]);
    bus(EMB_OFS_PROD_H, 0, 32'h0, 4'hF);
    chk("prod_h", rdq, {22'h0, 1'b1, last[36], 4'h0, last[35:32]});
    bus(EMB_OFS_PROD_L, 1, 32'h0, 4'hF);
    bus(EMB_OFS_CTRL, 1, 32'h0, 4'hE);
    bus(EMB_OFS_CTRL, 0, 32'h0, 4'hF);
    chk("ctrl", rdq, 32'h1F);
    bus(4'hC, 0, 32'h0, 4'hF);
    chk("unmapped", rdq, 32'h0);
    chk("held", {psg, prod}, last);
    aclr <= 1;
    @(negedge clk);
    chk("clear", {psg, prod}, 37'h0);
    @(posedge clk);
    aclr <= 0;
    end_sim();
  end
  initial begin
    #100000;
    err_total++;
    end_sim();
  end
endmodule
bind emb_mul emb_mul_sva chk_sva (.*);
